// ==== hw/ocb_stage.sv ====
// One overcurrent stage instance: blocking, status, events and fault records.
// Assumes measurements in 0.01 In units from same-clock logic and an APB master.
`timescale 1ns/1ps
module ocb_stage import ocb_pkg::*; #(
   parameter int CYC_PER_MS = CYCLES_PER_MS_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic block_in,
   input wire ocb_meas_s meas,
   input wire logic [15:0] harm2_ratio,
   input wire logic [2:0] setting_group,
   output logic start_out,
   output logic trip_out,
   output logic blocked_out,
   output ocb_cond_e condition,
   output logic [3:0] phase_cond,
   output ocb_event_s evt
);

   function automatic logic [15:0] max2(input logic [15:0] x, input logic [15:0] y);
      max2 = (x > y) ? x : y;
   endfunction : max2

   function automatic logic [5:0] hist_back(input logic [5:0] ptr, input logic [5:0] n);
      hist_back = (ptr >= n) ? ptr - n : ptr + 6'(HIST_DEPTH) - n;
   endfunction : hist_back

   ////////////////////////////////////////////////////////////////////////////
   // Time base and pin synchroniser
   logic [31:0] ms_count;
   logic tick;
   logic blk_meta, blk_sync;

   ocb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .ms_count(ms_count),
      .tick(tick)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         blk_meta <= 1'b0;
         blk_sync <= 1'b0;
      end else begin
         blk_meta <= block_in;
         blk_sync <= blk_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic inrush_en, inverse_mode, clr_req;
   logic [15:0] pickup_threshold, harm_limit;
   logic [19:0] op_delay;
   logic [8:0] on_mask, off_mask;
   logic [3:0] fault_sel;

   wire setup = psel && !penable;
   wire access = psel && penable && !pready;
   // Writes land on the completing edge, when pready is seen high
   wire wr_acc = psel && penable && pready && pwrite;
   wire wr_ctrl = wr_acc && (paddr == OFS_CTRL);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inrush_en <= 1'b0;
         inverse_mode <= 1'b0;
         clr_req <= 1'b0;
         pickup_threshold <= THRESH_RST;
         harm_limit <= HARM_RST;
         op_delay <= DELAY_RST;
         on_mask <= MASK_RST;
         off_mask <= MASK_RST;
         fault_sel <= '0;
      end else begin
         clr_req <= wr_ctrl && pwdata[CTRL_CLR_BIT];
         if (wr_ctrl) begin
            inrush_en <= pwdata[CTRL_INRUSH_BIT];
            inverse_mode <= pwdata[CTRL_INV_BIT];
         end
         if (wr_acc && paddr == OFS_THRESH) pickup_threshold <= pwdata[15:0];
         if (wr_acc && paddr == OFS_HARM) harm_limit <= pwdata[15:0];
         if (wr_acc && paddr == OFS_DELAY) op_delay <= pwdata[19:0];
         if (wr_acc && paddr == OFS_ON_MASK) on_mask <= pwdata[8:0];
         if (wr_acc && paddr == OFS_OFF_MASK) off_mask <= pwdata[8:0];
         if (wr_acc && paddr == OFS_FSEL) fault_sel <= pwdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pick-up with hysteresis and ratio
   logic [2:0] ph_pick;
   wire [15:0] max_i = max2(max2(meas.a, meas.b), meas.c);
   wire [22:0] thr_hi = {7'h00, pickup_threshold} * 23'(PCT_FULL);
   wire [22:0] thr_lo = {7'h00, pickup_threshold} * 23'(HYST_PCT);
   wire [47:0] meas_v = {meas.a, meas.b, meas.c};
   logic [2:0] next_ph_pick;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         logic [22:0] m;
         m = {7'h00, meas_v[16*(2-i) +: 16]} * 23'(PCT_FULL);
         if (m > thr_hi) next_ph_pick[i] = 1'b1;
         else if (m < thr_lo) next_ph_pick[i] = 1'b0;
         else next_ph_pick[i] = ph_pick[i];
      end
   end

   wire [22:0] ratio_full = (pickup_threshold == '0) ? '1 :
                            ({7'h00, max_i} * 23'(PCT_FULL)) / {7'h00, pickup_threshold};
   wire [16:0] ratio = (ratio_full > 23'h01_FFFF) ? '1 : ratio_full[16:0];

   // Inverse mode shortens the delay with rising multiple of threshold
   wire [26:0] inv_num = {7'h00, op_delay} * 27'(PCT_FULL);
   wire [26:0] inv_t = (ratio > RATIO_UNITY) ? inv_num / {10'h000, ratio - RATIO_UNITY} : 27'(MAX_TICKS);
   wire [19:0] inv_ticks = (inv_t > 27'(MAX_TICKS)) ? MAX_TICKS : inv_t[19:0];
   wire [19:0] exp_ticks = inverse_mode ? inv_ticks : op_delay;

   ////////////////////////////////////////////////////////////////////////////
   // Stage state machine, stepped once per program cycle
   ocb_cond_e state, next_state;
   logic [19:0] elapsed, next_elapsed;
   logic blk_cycle;
   wire pick = |next_ph_pick;
   wire inrush_blk = inrush_en && (harm2_ratio > harm_limit);
   wire blk_now = blk_sync || inrush_blk;

   always_comb begin
      next_state = state;
      next_elapsed = elapsed;
      if (!pick) begin
         next_state = OCB_NORMAL;
         next_elapsed = '0;
      end else if (blk_now) begin
         next_state = OCB_BLOCKED;
         next_elapsed = '0;
      end else begin
         case (state)
            OCB_NORMAL, OCB_BLOCKED: begin
               next_state = OCB_START;
               next_elapsed = '0;
            end
            OCB_START: begin
               next_elapsed = elapsed + 20'h0_0001;
               if (next_elapsed >= exp_ticks) next_state = OCB_TRIP;
            end
            OCB_TRIP: next_elapsed = elapsed;
            default: next_state = OCB_NORMAL;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= OCB_NORMAL;
         elapsed <= '0;
         ph_pick <= '0;
         blk_cycle <= 1'b0;
      end else if (tick) begin
         state <= next_state;
         elapsed <= next_elapsed;
         ph_pick <= next_ph_pick;
         blk_cycle <= blk_now;
      end
   end

   wire timing = (state == OCB_START) || (state == OCB_TRIP);
   wire [2:0] ph_start = timing ? ph_pick : 3'h0;
   wire [2:0] ph_trip = (state == OCB_TRIP) ? ph_pick : 3'h0;
   wire [19:0] remaining = (exp_ticks > elapsed) ? exp_ticks - elapsed : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         start_out <= 1'b0;
         trip_out <= 1'b0;
         blocked_out <= 1'b0;
         condition <= OCB_NORMAL;
         phase_cond <= '0;
      end else begin
         start_out <= timing;
         trip_out <= (state == OCB_TRIP);
         blocked_out <= (state == OCB_BLOCKED);
         condition <= state;
         phase_cond <= {state == OCB_TRIP, ph_start};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event edges, pending set and serial output
   logic [8:0] lv_prev;
   logic [17:0] pending;
   logic lv_valid;
   wire [8:0] lv = {ph_trip, ph_start, state == OCB_BLOCKED, state == OCB_TRIP, timing};
   wire [8:0] rise = lv & ~lv_prev;
   wire [8:0] fall = ~lv & lv_prev;
   logic [17:0] new_ev;
   logic [17:0] grant;
   logic [4:0] grant_code;

   always_comb begin
      new_ev = '0;
      for (int i = 0; i < NUM_LV; i++) begin
         new_ev[2*i] = rise[i] && on_mask[i];
         new_ev[2*i+1] = fall[i] && off_mask[i];
      end
   end

   always_comb begin
      grant = '0;
      grant_code = '0;
      for (int i = 17; i >= 0; i--) begin
         if (pending[i]) begin
            grant = 18'(1) << i;
            grant_code = 5'(i);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lv_prev <= '0;
         lv_valid <= 1'b0;
         pending <= '0;
         evt <= '0;
      end else begin
         lv_prev <= lv;
         lv_valid <= 1'b1;
         // New edges win over the grant of the same cycle
         pending <= (pending & ~grant) | (lv_valid ? new_ev : '0);
         evt.valid <= |pending;
         evt.code <= grant_code;
         evt.stamp <= ms_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Current history, counters and fault records
   logic [15:0] hist [HIST_DEPTH];
   logic [5:0] hist_ptr;
   logic [15:0] cnt_start, cnt_trip, cnt_blk;
   ocb_fault_s rec_in, rec_out;
   logic [3:0] fill;
   wire on_start = lv_valid && rise[LV_START];
   wire on_trip = lv_valid && rise[LV_TRIP];
   wire on_blk = lv_valid && rise[LV_BLOCK];
   wire rec_wr = on_start || on_trip || on_blk;

   always_comb begin
      rec_in.stamp = ms_count;
      rec_in.evt = on_trip ? OCB_TRIP : (on_start ? OCB_START : OCB_BLOCKED);
      rec_in.ftype = ph_pick;
      rec_in.pre_trig = hist[hist_back(hist_ptr, 6'(PRE_TRIG_TICKS))];
      rec_in.fault_cur = max_i;
      rec_in.pre_fault = hist[hist_ptr];
      rec_in.remaining = remaining;
      rec_in.group = setting_group;
   end

   always_ff @(posedge ref_clk) begin
      if (tick) hist[hist_ptr] <= max_i;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hist_ptr <= '0;
         cnt_start <= '0;
         cnt_trip <= '0;
         cnt_blk <= '0;
      end else begin
         if (tick) hist_ptr <= (hist_ptr == 6'(HIST_DEPTH - 1)) ? '0 : hist_ptr + 6'h01;
         // A clear with a simultaneous occurrence leaves a count of one
         if (on_start) cnt_start <= (clr_req ? '0 : cnt_start) + 16'h0001;
         else if (clr_req) cnt_start <= '0;
         if (on_trip) cnt_trip <= (clr_req ? '0 : cnt_trip) + 16'h0001;
         else if (clr_req) cnt_trip <= '0;
         if (on_blk) cnt_blk <= (clr_req ? '0 : cnt_blk) + 16'h0001;
         else if (clr_req) cnt_blk <= '0;
      end
   end

   ocb_fault_store u_store (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(rec_wr),
      .wr_data(rec_in),
      .rd_age(fault_sel),
      .rd_data(rec_out),
      .fill(fill)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB read decode; one wait state on every access
   logic [31:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      case (paddr)
         OFS_CTRL: rd_mux = {29'h0, 1'b0, inverse_mode, inrush_en};
         OFS_THRESH: rd_mux = {16'h0000, pickup_threshold};
         OFS_HARM: rd_mux = {16'h0000, harm_limit};
         OFS_DELAY: rd_mux = {12'h000, op_delay};
         OFS_ON_MASK: rd_mux = {23'h0, on_mask};
         OFS_OFF_MASK: rd_mux = {23'h0, off_mask};
         OFS_FSEL: rd_mux = {28'h000_0000, fault_sel};
         OFS_STATUS: rd_mux = {23'h0, blk_cycle, phase_cond, 2'b00, condition};
         OFS_EXP: rd_mux = {12'h000, exp_ticks};
         OFS_REM: rd_mux = {12'h000, timing ? remaining : 20'h0_0000};
         OFS_RATIO: rd_mux = {15'h0000, ratio};
         OFS_CNT_ST: rd_mux = {16'h0000, cnt_start};
         OFS_CNT_TR: rd_mux = {16'h0000, cnt_trip};
         OFS_CNT_BL: rd_mux = {16'h0000, cnt_blk};
         OFS_FCNT: rd_mux = {28'h000_0000, fill};
         OFS_FW0: rd_mux = rec_out.stamp;
         OFS_FW1: rd_mux = {rec_out.pre_trig, rec_out.fault_cur};
         OFS_FW2: rd_mux = {rec_out.pre_fault, 8'h00, rec_out.group, rec_out.ftype, rec_out.evt};
         OFS_FW3: rd_mux = {12'h000, rec_out.remaining};
         OFS_TIME: rd_mux = ms_count;
         default: begin
            rd_mux = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access && !rd_hit;
         if (access && !pwrite) prdata <= rd_mux;
         else if (setup) prdata <= '0;
      end
   end

endmodule : ocb_stage

// ==== hw/ocb_pkg.sv ====
// Shared constants, types and register map of the overcurrent stage.
// Assumes a 100 MHz ref_clk and an APB master with 32-bit data.
package ocb_pkg;

   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS_DEF = CLK_HZ / MS_PER_S;
   localparam int PROG_CYCLE_MS = 5;
   localparam int PRE_TRIG_MS = 20;
   localparam int PRE_FAULT_MS = 200;
   localparam int PRE_TRIG_TICKS = PRE_TRIG_MS / PROG_CYCLE_MS;
   localparam int HIST_DEPTH = PRE_FAULT_MS / PROG_CYCLE_MS;
   localparam int FAULT_DEPTH = 12;
   localparam int MAX_TIME_MS = 1_800_000;
   localparam logic [19:0] MAX_TICKS = 20'(MAX_TIME_MS / PROG_CYCLE_MS);
   localparam logic [16:0] RATIO_UNITY = 17'h0_0064;
   localparam logic [6:0] HYST_PCT = 7'h61;
   localparam logic [6:0] PCT_FULL = 7'h64;

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_THRESH = 12'h004;
   localparam logic [11:0] OFS_HARM = 12'h008;
   localparam logic [11:0] OFS_DELAY = 12'h00C;
   localparam logic [11:0] OFS_ON_MASK = 12'h010;
   localparam logic [11:0] OFS_OFF_MASK = 12'h014;
   localparam logic [11:0] OFS_FSEL = 12'h018;
   localparam logic [11:0] OFS_STATUS = 12'h020;
   localparam logic [11:0] OFS_EXP = 12'h024;
   localparam logic [11:0] OFS_REM = 12'h028;
   localparam logic [11:0] OFS_RATIO = 12'h02C;
   localparam logic [11:0] OFS_CNT_ST = 12'h030;
   localparam logic [11:0] OFS_CNT_TR = 12'h034;
   localparam logic [11:0] OFS_CNT_BL = 12'h038;
   localparam logic [11:0] OFS_FCNT = 12'h03C;
   localparam logic [11:0] OFS_FW0 = 12'h040;
   localparam logic [11:0] OFS_FW1 = 12'h044;
   localparam logic [11:0] OFS_FW2 = 12'h048;
   localparam logic [11:0] OFS_FW3 = 12'h04C;
   localparam logic [11:0] OFS_TIME = 12'h050;

   // Control field positions and reset values
   localparam int CTRL_INRUSH_BIT = 0;
   localparam int CTRL_INV_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam logic [15:0] THRESH_RST = 16'h0078;
   localparam logic [15:0] HARM_RST = 16'h0001;
   localparam logic [19:0] DELAY_RST = 20'h0_0014;
   localparam logic [8:0] MASK_RST = 9'h1FF;

   // Level index order; event code = 2*index + (1 for OFF)
   localparam int LV_START = 0;
   localparam int LV_TRIP = 1;
   localparam int LV_BLOCK = 2;
   localparam int LV_PH_ST = 3;
   localparam int LV_PH_TR = 6;
   localparam int NUM_LV = 9;

   typedef enum logic [1:0] {
      OCB_NORMAL = 2'b00,
      OCB_START = 2'b01,
      OCB_TRIP = 2'b11,
      OCB_BLOCKED = 2'b10
   } ocb_cond_e;

   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] c;
   } ocb_meas_s;

   typedef struct packed {
      logic valid;
      logic [4:0] code;
      logic [31:0] stamp;
   } ocb_event_s;

   typedef struct packed {
      logic [31:0] stamp;
      ocb_cond_e evt;
      logic [2:0] ftype;
      logic [15:0] pre_trig;
      logic [15:0] fault_cur;
      logic [15:0] pre_fault;
      logic [19:0] remaining;
      logic [2:0] group;
   } ocb_fault_s;

endpackage : ocb_pkg

// ==== hw/ocb_ms_timer.sv ====
// Millisecond time base and 5 ms program-cycle tick of one stage instance.
// Assumes one instance inside each stage instance, feeding only that stage.
`timescale 1ns/1ps
module ocb_ms_timer import ocb_pkg::*; #(
   parameter int CYC_PER_MS = CYCLES_PER_MS_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   output logic [31:0] ms_count,
   output logic tick
);
   logic [31:0] div;
   logic [2:0] ms_in_cycle;
   wire ms_done = (div == 32'(CYC_PER_MS - 1));
   wire cyc_done = ms_done && (ms_in_cycle == 3'(PROG_CYCLE_MS - 1));

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div <= '0;
         ms_in_cycle <= '0;
         ms_count <= '0;
         tick <= 1'b0;
      end else begin
         div <= ms_done ? '0 : div + 32'h0000_0001;
         if (ms_done) begin
            ms_count <= ms_count + 32'h0000_0001;
            ms_in_cycle <= cyc_done ? '0 : ms_in_cycle + 3'h1;
         end
         tick <= cyc_done;
      end
   end
endmodule : ocb_ms_timer

// ==== hw/ocb_fault_store.sv ====
// Circular store of the last twelve fault records of one instance.
// Assumes at most one write per clock; read is combinational.
`timescale 1ns/1ps
module ocb_fault_store import ocb_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire ocb_fault_s wr_data,
   input wire logic [3:0] rd_age,
   output ocb_fault_s rd_data,
   output logic [3:0] fill
);
   ocb_fault_s mem [FAULT_DEPTH];
   logic [3:0] wr_ptr;
   // Age 0 is the newest record
   wire [4:0] back = {1'b0, wr_ptr} + 5'(FAULT_DEPTH - 1) - {1'b0, rd_age};
   wire [3:0] rd_idx = (back >= 5'(FAULT_DEPTH)) ? 4'(back - 5'(FAULT_DEPTH)) : back[3:0];
   assign rd_data = (rd_age < fill) ? mem[rd_idx] : '0;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         fill <= '0;
      end else if (wr_en) begin
         mem[wr_ptr] <= wr_data;
         wr_ptr <= (wr_ptr == 4'(FAULT_DEPTH - 1)) ? '0 : wr_ptr + 4'h1;
         if (fill != 4'(FAULT_DEPTH)) fill <= fill + 4'h1;
      end
   end
endmodule : ocb_fault_store

// ==== sim/ocb_stage_chk.sv ====
// Port checker for ocb_stage, bound into every instance.
// Assumes the default ON mask, so each start gives a start ON event.
`timescale 1ns/1ps
module ocb_stage_chk import ocb_pkg::*; #(
   parameter int CYC_PER_MS = CYCLES_PER_MS_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic start_out,
   input wire logic trip_out,
   input wire logic blocked_out,
   input wire ocb_cond_e condition,
   input wire logic [3:0] phase_cond,
   input wire ocb_event_s evt
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   sequence s_first_access; psel && penable && !pready; endsequence
   sequence s_start_evt; ##[1:4] (evt.valid && evt.code == 5'h00); endsequence
   property p_wait_one; s_first_access |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_err_rdy; pslverr |-> pready; endproperty
   property p_trip_map; trip_out |-> start_out && !blocked_out && condition == OCB_TRIP; endproperty
   property p_block_map; blocked_out |-> !start_out && condition == OCB_BLOCKED; endproperty
   property p_start_map; condition == OCB_START |-> start_out && !phase_cond[3] && phase_cond[2:0] != 3'h0; endproperty
   property p_norm_phase; condition == OCB_NORMAL |-> phase_cond == 4'h0 && !start_out; endproperty
   // State moves only on the program-cycle tick, far apart
   property p_hold; !$stable(condition) |=> $stable(condition) [*8]; endproperty
   property p_start_evt; $rose(start_out) |-> s_start_evt; endproperty
   ////////////////////////////////////////////////////////////////////////
   a_wait_one: assert property (p_wait_one) else $error("pready late");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   a_trip_map: assert property (p_trip_map) else $error("trip status mismatch");
   a_block_map: assert property (p_block_map) else $error("blocked with start");
   a_start_map: assert property (p_start_map) else $error("start status mismatch");
   a_norm_phase: assert property (p_norm_phase) else $error("normal phase mismatch");
   a_hold: assert property (p_hold) else $error("condition changed off tick");
   a_start_evt: assert property (p_start_evt) else $error("start event missing");
endmodule : ocb_stage_chk

bind ocb_stage ocb_stage_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
   .blocked_out(blocked_out), .condition(condition), .phase_cond(phase_cond), .evt(evt));

// ==== sim/ocb_far.sv ====
// Far side: measurement front end, blocking matrix and event buffer.
// Assumes bench levels change just after a clock edge.
`timescale 1ns/1ps
module ocb_far import ocb_pkg::*; (
   input wire logic ref_clk,
   input wire logic clr,
   input wire ocb_meas_s cur,
   input wire logic blk_req,
   input wire logic [15:0] harm_req,
   input wire ocb_event_s evt,
   output ocb_meas_s meas,
   output logic block_in,
   output logic [15:0] harm2_ratio,
   output logic [17:0] seen,
   output logic bad_order
);
   logic [31:0] last_stamp;
   assign meas = cur;
   // Bench raises block at least one tick before expiry
   assign block_in = blk_req;
   assign harm2_ratio = harm_req;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (clr) begin
         seen <= '0;
         last_stamp <= '0;
         bad_order <= 1'b0;
      end else if (evt.valid) begin
         seen[evt.code] <= 1'b1;
         last_stamp <= evt.stamp;
         // Stamps from one time base never run backwards
         if (evt.stamp < last_stamp) begin
            bad_order <= 1'b1;
         end
      end
   end
endmodule : ocb_far

// ==== sim/overcurrent_block_event_logic_test.sv ====
// Testbench for ocb_stage: APB register calls and fault sequences.
// Assumes ocb_far as far side and a 100 MHz clock.
`timescale 1ns/1ps
module overcurrent_block_event_logic_test import ocb_pkg::*;;
   localparam int CPM = 10;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, blk, clr, e;
   logic start_out, trip_out, blocked_out, block_in, bad_order;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] harm, harm2_ratio;
   logic [2:0] grp;
   logic [3:0] phase_cond;
   logic [17:0] ev_seen;
   ocb_meas_s cur, meas;
   ocb_cond_e condition;
   ocb_event_s evt;
   int err_count, check_count;

   ocb_stage #(.CYC_PER_MS(CPM)) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .block_in(block_in), .meas(meas), .harm2_ratio(harm2_ratio), .setting_group(grp),
      .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .condition(condition),
      .phase_cond(phase_cond), .evt(evt));
   ocb_far u_far (.ref_clk(ref_clk), .clr(clr), .cur(cur), .blk_req(blk), .harm_req(harm), .evt(evt),
      .meas(meas), .block_in(block_in), .harm2_ratio(harm2_ratio), .seen(ev_seen), .bad_order(bad_order));

   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Entered just after an edge; leaves one idle edge so calls never collide
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (n == 20) begin
         err_count++;
         give_verdict();
      end
   endtask : apb

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, q, x);
   endtask : rdc

   task automatic wait_cond(input ocb_cond_e c);
      int n;
      n = 0;
      while (condition !== c && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("condition", condition, c);
      if (condition !== c) give_verdict();
   endtask : wait_cond
   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      check_count = 0;
      ref_clk = 1'b0;
      rst = 1'b1;
      clr = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cur = '0;
      blk = 1'b0;
      harm = 16'h0000;
      grp = 3'h3;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      clr <= 1'b0;
      rdc("thresh", OFS_THRESH, 32'(THRESH_RST));
      rdc("harm_lim", OFS_HARM, 32'(HARM_RST));
      rdc("delay", OFS_DELAY, 32'(DELAY_RST));
      apb(1'b0, 12'h01C, 32'h0000_0000);
      chk("unmapped_err", e, 32'h0000_0001);
      $display("test reset_values done");
      apb(1'b1, OFS_DELAY, 32'h0000_0003);
      cur.a <= 16'h00F0;
      wait_cond(OCB_START);
      chk("phase_a", phase_cond, 32'h0000_0001);
      apb(1'b0, OFS_REM, 32'h0000_0000);
      chk("rem_range", q > 0 && q < 4, 32'h0000_0001);
      rdc("expected", OFS_EXP, 32'h0000_0003);
      rdc("ratio", OFS_RATIO, 32'h0000_00C8);
      wait_cond(OCB_TRIP);
      chk("phase_trip", phase_cond[3], 32'h0000_0001);
      chk("trip_out", trip_out, 32'h0000_0001);
      cur.a <= 16'h0075;
      repeat (150) @(posedge ref_clk);
      chk("hyst_hold", condition, OCB_TRIP);
      cur.a <= 16'h0074;
      wait_cond(OCB_NORMAL);
      rdc("cnt_start", OFS_CNT_ST, 32'h0000_0001);
      rdc("cnt_trip", OFS_CNT_TR, 32'h0000_0001);
      rdc("fill", OFS_FCNT, 32'h0000_0002);
      apb(1'b0, OFS_FW2, 32'h0000_0000);
      chk("rec_group_evt", {q[7:5], q[1:0]}, 32'h0000_000F);
      apb(1'b0, OFS_FW1, 32'h0000_0000);
      chk("rec_fault_cur", q[15:0], 32'h0000_00F0);
      chk("events", ev_seen & 18'h0_1047, 32'h0000_1047);
      $display("test start_trip done");
      blk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cur.a <= 16'h00F0;
      wait_cond(OCB_BLOCKED);
      chk("start_blk", start_out, 32'h0000_0000);
      rdc("status_blk", OFS_STATUS, 32'h0000_0102);
      cur.a <= 16'h0000;
      blk <= 1'b0;
      wait_cond(OCB_NORMAL);
      rdc("cnt_blk", OFS_CNT_BL, 32'h0000_0001);
      cur.a <= 16'h00F0;
      wait_cond(OCB_START);
      blk <= 1'b1;
      wait_cond(OCB_BLOCKED);
      cur.a <= 16'h0000;
      blk <= 1'b0;
      wait_cond(OCB_NORMAL);
      $display("test blocking done");
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      harm <= 16'h01F4;
      cur.a <= 16'h00F0;
      wait_cond(OCB_BLOCKED);
      cur.a <= 16'h0000;
      wait_cond(OCB_NORMAL);
      harm <= 16'h0000;
      $display("test inrush done");
      apb(1'b1, OFS_CTRL, 32'h0000_0002);
      apb(1'b1, OFS_DELAY, 32'h0000_0014);
      cur <= '{16'h0168, 16'h0168, 16'h0000};
      wait_cond(OCB_START);
      chk("phase_ab", phase_cond, 32'h0000_0003);
      rdc("exp_inv", OFS_EXP, 32'h0000_000A);
      rdc("ratio_inv", OFS_RATIO, 32'h0000_012C);
      cur <= '0;
      wait_cond(OCB_NORMAL);
      chk("stamp_order", bad_order, 32'h0000_0000);
      $display("test inverse done");
      clr <= 1'b1;
      apb(1'b1, OFS_OFF_MASK, 32'h0000_0000);
      clr <= 1'b0;
      cur.a <= 16'h00F0;
      wait_cond(OCB_START);
      cur.a <= 16'h0000;
      wait_cond(OCB_NORMAL);
      repeat (20) @(posedge ref_clk);
      chk("off_masked", ev_seen & 18'h0_0003, 32'h0000_0001);
      apb(1'b1, OFS_CTRL, 32'h0000_0004);
      rdc("cnt_clr", OFS_CNT_ST, 32'h0000_0000);
      $display("test masks_clear done");
      give_verdict();
   end
endmodule : overcurrent_block_event_logic_test
